// ===== design/hes_host_error_bank.sv
// Host error status bank: four sticky fault registers and the summary flag.
`timescale 1ns/1ps
module hes_host_error_bank (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic [7:0]          regAddr,
   input  wire logic                regWriteEn,
   input  wire logic [7:0]          regWriteData,
   output logic [7:0]               regReadData,
   input  wire hes_pkg::hes_sleep_t sleepState,
   input  wire logic [7:0]          zoneMaskSelect,
   input  wire logic [7:0]          voltageMaskSelect,
   input  wire logic [7:0]          diodeMaskSelect,
   input  wire logic [3:0]          zoneLimitFault,
   input  wire logic                regulatorOneHotInput,
   input  wire logic                regulatorTwoHotInputN,
   input  wire logic [15:0]         voltageChannelFault,
   input  wire logic [3:0]          diodePairFault,
   input  wire logic                fuseInputEight,
   input  wire logic                fuseInputNine,
   input  wire logic                olderRegulatorStandard,
   input  wire logic                coreSupplyOneMismatch,
   input  wire logic                coreSupplyTwoMismatch,
   output logic                     hostErrorFlag
);
   import hes_pkg::*;

   localparam logic [NUM_REGS-1:0][7:0] ADDRS =
      {DIODE_REG_ADDR, VHIGH_REG_ADDR, VLOW_REG_ADDR, ZONE_REG_ADDR};
   localparam logic [NUM_REGS-1:0][7:0] IMPLS =
      {DIODE_IMPL, VHIGH_IMPL, VLOW_IMPL, ZONE_IMPL};
   localparam logic [NUM_REGS-1:0][7:0] ALWAYS =
      {DIODE_ALWAYS, VHIGH_ALWAYS, VLOW_ALWAYS, ZONE_ALWAYS};
   localparam logic [NUM_REGS-1:0][7:0] OPTS =
      {DIODE_OPT, VHIGH_OPT, VLOW_OPT, ZONE_OPT};

   logic                         sleeping;
   logic [NUM_REGS-1:0][REG_W-1:0] events;
   logic [NUM_REGS-1:0][REG_W-1:0] optSel;
   logic [NUM_REGS-1:0][REG_W-1:0] status;
   logic [7:0]                   next_readData;
   logic                         fuseEnable;

   // Only S3 and S4/5 mask anything in this bank.
   assign sleeping = (sleepState == SLEEP_S3) ||
                     (sleepState == SLEEP_S45);

   // Fuse inputs mean nothing under the newer code mode, so gate them here.
   assign fuseEnable = olderRegulatorStandard;

   assign events[ZONE_IDX] = {2'b00,
                              ~regulatorTwoHotInputN,
                              regulatorOneHotInput,
                              zoneLimitFault};
   assign events[VLOW_IDX]  = voltageChannelFault[7:0];
   assign events[VHIGH_IDX] = voltageChannelFault[15:8];
   assign events[DIODE_IDX] = {diodePairFault[3], diodePairFault[2],
                               coreSupplyTwoMismatch,
                               coreSupplyOneMismatch,
                               fuseInputNine & fuseEnable,
                               fuseInputEight & fuseEnable,
                               diodePairFault[1], diodePairFault[0]};

   assign optSel[ZONE_IDX]  = zoneMaskSelect;
   assign optSel[VLOW_IDX]  = voltageMaskSelect;
   assign optSel[VHIGH_IDX] = voltageMaskSelect;
   assign optSel[DIODE_IDX] = diodeMaskSelect;

   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++) begin : gen_reg
         hes_status_reg #(
            .IMPL_MASK   (IMPLS[g]),
            .ALWAYS_MASK (ALWAYS[g]),
            .OPT_MASK    (OPTS[g])
         ) u_reg (
            .clk           (clk),
            .rst           (rst),
            .eventIn       (events[g]),
            .sleeping      (sleeping),
            .optMaskSelect (optSel[g]),
            .writeClear    (regWriteEn && (regAddr == ADDRS[g])),
            .writeData     (regWriteData),
            .status        (status[g])
         );
      end
   endgenerate

   // The flag follows the bits directly so clearing the last bit drops it.
   assign hostErrorFlag = |status;

   always_comb begin
      next_readData = READ_UNMAPPED;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (regAddr == ADDRS[i]) begin
            next_readData = status[i];
         end
      end
   end

   // Read data is sampled every cycle from the presented address.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         regReadData <= STATUS_RESET;
      end else begin
         regReadData <= next_readData;
      end
   end

   // Sleep checks watch bits that are clear, since a bit set before sleep stays.
   a_zone_one_set: assert property (@(posedge clk) disable iff (rst)
      zoneLimitFault[0] && !sleeping |=> status[ZONE_IDX][0])
      else $error("zone one fault not latched");
   a_zone_two_set: assert property (@(posedge clk) disable iff (rst)
      zoneLimitFault[1] && !sleeping |=> status[ZONE_IDX][1])
      else $error("zone two fault not latched");
   a_zone_opt_open: assert property (@(posedge clk) disable iff (rst)
      sleeping |=> ((~status[ZONE_IDX] & ZONE_OPT & ~$past(zoneMaskSelect)
         & {4'h0, $past(zoneLimitFault)}) == 8'h00))
      else $error("unselected zone fault masked in sleep");
   a_zone_opt_held: assert property (@(posedge clk) disable iff (rst)
      sleeping && ((status[ZONE_IDX] & ZONE_OPT & zoneMaskSelect) == 8'h00)
      |=> ((status[ZONE_IDX] & ZONE_OPT & $past(zoneMaskSelect)) == 8'h00))
      else $error("selected zone fault set in sleep");
   a_zone_three_nomask: assert property (@(posedge clk) disable iff (rst)
      zoneLimitFault[2] |=> status[ZONE_IDX][2])
      else $error("zone three fault masked");
   a_zone_four_nomask: assert property (@(posedge clk) disable iff (rst)
      zoneLimitFault[3] |=> status[ZONE_IDX][3])
      else $error("zone four fault masked");
   a_reg_one_set: assert property (@(posedge clk) disable iff (rst)
      regulatorOneHotInput && !sleeping
      |=> status[ZONE_IDX][BIT_REG_ONE_HOT])
      else $error("regulator one hot not latched");
   a_reg_hot_masked: assert property (@(posedge clk) disable iff (rst)
      sleeping && !status[ZONE_IDX][BIT_REG_ONE_HOT] && !regWriteEn
      |=> !status[ZONE_IDX][BIT_REG_ONE_HOT])
      else $error("regulator one hot set during sleep");
   a_reg_two_low: assert property (@(posedge clk) disable iff (rst)
      !regulatorTwoHotInputN && !sleeping
      |=> status[ZONE_IDX][BIT_REG_TWO_HOT])
      else $error("regulator two hot not latched");
   a_reg_two_masked: assert property (@(posedge clk) disable iff (rst)
      sleeping && !status[ZONE_IDX][BIT_REG_TWO_HOT]
      |=> !status[ZONE_IDX][BIT_REG_TWO_HOT])
      else $error("regulator two hot set during sleep");
   a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
      regAddr == ZONE_REG_ADDR |=> regReadData[7:6] == 2'b00)
      else $error("reserved bits read nonzero");

   // The two voltage registers share one optional mask selection.
   a_low_bank_set: assert property (@(posedge clk) disable iff (rst)
      !sleeping |=> ((~status[VLOW_IDX]
         & $past(voltageChannelFault[7:0])) == 8'h00))
      else $error("low voltage bank fault not latched");
   a_low_bank_masked: assert property (@(posedge clk) disable iff (rst)
      sleeping && (status[VLOW_IDX] == 8'h00)
      |=> (status[VLOW_IDX] == 8'h00))
      else $error("low voltage bank set during sleep");
   a_high_bank_set: assert property (@(posedge clk) disable iff (rst)
      !sleeping |=> ((~status[VHIGH_IDX]
         & $past(voltageChannelFault[15:8])) == 8'h00))
      else $error("high voltage bank fault not latched");
   a_high_always: assert property (@(posedge clk) disable iff (rst)
      sleeping && ((status[VHIGH_IDX] & VHIGH_ALWAYS) == 8'h00)
      |=> ((status[VHIGH_IDX] & VHIGH_ALWAYS) == 8'h00))
      else $error("always masked channel set during sleep");
   a_high_opt_open: assert property (@(posedge clk) disable iff (rst)
      sleeping |=> ((~status[VHIGH_IDX] & VHIGH_OPT
         & ~$past(voltageMaskSelect)
         & $past(voltageChannelFault[15:8])) == 8'h00))
      else $error("unselected channel fault masked in sleep");
   a_high_opt_held: assert property (@(posedge clk) disable iff (rst)
      sleeping
      && ((status[VHIGH_IDX] & VHIGH_OPT & voltageMaskSelect) == 8'h00)
      |=> ((status[VHIGH_IDX] & VHIGH_OPT & $past(voltageMaskSelect))
         == 8'h00))
      else $error("selected channel fault set in sleep");
   a_chan_sixteen: assert property (@(posedge clk) disable iff (rst)
      voltageChannelFault[15] |=> status[VHIGH_IDX][BIT_CHAN_SIXTEEN])
      else $error("channel sixteen fault masked");

   // Diode faults are optional; fuse and core supply bits always mask.
   a_diode_opt_open: assert property (@(posedge clk) disable iff (rst)
      sleeping |=> ((~status[DIODE_IDX] & DIODE_OPT
         & ~$past(diodeMaskSelect)
         & $past({diodePairFault[3:2], 4'h0, diodePairFault[1:0]}))
         == 8'h00))
      else $error("unselected diode fault masked in sleep");
   a_diode_always: assert property (@(posedge clk) disable iff (rst)
      sleeping && ((status[DIODE_IDX] & DIODE_ALWAYS) == 8'h00)
      |=> ((status[DIODE_IDX] & DIODE_ALWAYS) == 8'h00))
      else $error("always masked diode bank bit set in sleep");
   a_core_set: assert property (@(posedge clk) disable iff (rst)
      !sleeping |=> ((~status[DIODE_IDX] & {2'b00,
         $past(coreSupplyTwoMismatch), $past(coreSupplyOneMismatch), 4'h0})
         == 8'h00))
      else $error("core supply mismatch not latched");
   a_fuse_gated: assert property (@(posedge clk) disable iff (rst)
      !olderRegulatorStandard && !status[DIODE_IDX][BIT_FUSE_EIGHT]
      |=> !status[DIODE_IDX][BIT_FUSE_EIGHT])
      else $error("fuse eight set outside older mode");
   a_fuse_nine_gated: assert property (@(posedge clk) disable iff (rst)
      !olderRegulatorStandard && !status[DIODE_IDX][BIT_FUSE_NINE]
      |=> !status[DIODE_IDX][BIT_FUSE_NINE])
      else $error("fuse nine set outside older mode");
   a_fuse_set: assert property (@(posedge clk) disable iff (rst)
      olderRegulatorStandard && fuseInputEight && !sleeping
      |=> status[DIODE_IDX][BIT_FUSE_EIGHT])
      else $error("fuse eight not latched in older mode");

   // The summary flag must rise together with the first latched bit.
   a_summary_flag: assert property (@(posedge clk) disable iff (rst)
      $rose(status[VLOW_IDX][0]) |-> hostErrorFlag ##1 $past(hostErrorFlag))
      else $error("summary flag missing");

endmodule

// ===== design/hes_pkg.sv
// Register offsets, bit masks and sleep state encoding for the host error bank.
package hes_pkg;

   localparam int REG_W = 8;
   localparam int NUM_REGS = 4;

   localparam logic [7:0] ZONE_REG_ADDR  = 8'h48;
   localparam logic [7:0] VLOW_REG_ADDR  = 8'h49;
   localparam logic [7:0] VHIGH_REG_ADDR = 8'h4a;
   localparam logic [7:0] DIODE_REG_ADDR = 8'h4b;
   localparam logic [7:0] STATUS_RESET   = 8'h00;
   localparam logic [7:0] READ_UNMAPPED  = 8'h00;

   // Bits that exist in each register; the rest read as zero.
   localparam logic [7:0] ZONE_IMPL  = 8'h3f;
   localparam logic [7:0] VLOW_IMPL  = 8'hff;
   localparam logic [7:0] VHIGH_IMPL = 8'hff;
   localparam logic [7:0] DIODE_IMPL = 8'hff;

   // Events masked in deep sleep regardless of configuration.
   localparam logic [7:0] ZONE_ALWAYS  = 8'h30;
   localparam logic [7:0] VLOW_ALWAYS  = 8'hff;
   localparam logic [7:0] VHIGH_ALWAYS = 8'h47;
   localparam logic [7:0] DIODE_ALWAYS = 8'h3c;

   // Events masked in deep sleep only when the mask selection asks for it.
   localparam logic [7:0] ZONE_OPT  = 8'h03;
   localparam logic [7:0] VLOW_OPT  = 8'h00;
   localparam logic [7:0] VHIGH_OPT = 8'h38;
   localparam logic [7:0] DIODE_OPT = 8'hc3;

   localparam int ZONE_IDX  = 0;
   localparam int VLOW_IDX  = 1;
   localparam int VHIGH_IDX = 2;
   localparam int DIODE_IDX = 3;

   localparam int BIT_REG_ONE_HOT = 4;
   localparam int BIT_REG_TWO_HOT = 5;
   localparam int BIT_FUSE_EIGHT  = 2;
   localparam int BIT_FUSE_NINE   = 3;
   localparam int BIT_CHAN_SIXTEEN = 7;

   typedef enum logic [1:0] {
      SLEEP_S0  = 2'b00,
      SLEEP_S1  = 2'b01,
      SLEEP_S3  = 2'b11,
      SLEEP_S45 = 2'b10
   } hes_sleep_t;

endpackage

// ===== design/hes_status_reg.sv
// One 8-bit sticky write-one-to-clear status register with sleep masking.
`timescale 1ns/1ps
module hes_status_reg #(
   parameter logic [7:0] IMPL_MASK   = 8'hff,
   parameter logic [7:0] ALWAYS_MASK = 8'h00,
   parameter logic [7:0] OPT_MASK    = 8'h00
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [7:0] eventIn,
   input  wire logic       sleeping,
   input  wire logic [7:0] optMaskSelect,
   input  wire logic       writeClear,
   input  wire logic [7:0] writeData,
   output logic [7:0]      status
);
   import hes_pkg::*;

   logic [7:0] effMask;
   logic [7:0] armed;
   logic [7:0] clearOk;

   // Optional masking only applies to bits that the register marks optional.
   assign effMask = sleeping ? (ALWAYS_MASK | (OPT_MASK & optMaskSelect))
                             : 8'h00;
   assign armed   = eventIn & ~effMask & IMPL_MASK;
   // A bit whose condition is still present refuses the clear.
   assign clearOk = writeClear ? (writeData & ~eventIn) : 8'h00;

   // Set wins over clear so an event in the clear cycle is never lost.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status <= STATUS_RESET;
      end else begin
         status <= ((status & ~clearOk) | armed) & IMPL_MASK;
      end
   end

   a_clear_refused: assert property (@(posedge clk) disable iff (rst)
      writeClear |=> (($past(status) & $past(eventIn) & ~status) == 8'h00))
      else $error("status bit cleared while its condition held");
   a_clear_done: assert property (@(posedge clk) disable iff (rst)
      writeClear && !sleeping |=> ((status & $past(writeData)
         & ~$past(eventIn)) == 8'h00))
      else $error("written one did not clear an idle bit");
   a_zero_keeps: assert property (@(posedge clk) disable iff (rst)
      writeClear |=> (($past(status) & ~$past(writeData) & ~status) == 8'h00))
      else $error("writing zero changed a status bit");

endmodule

// ===== sim/hes_host_model.sv
// Host software model: byte register reads and write-one-to-clear writes.
`timescale 1ns/1ps
module hes_host_model (
   input  wire logic       clk,
   output logic [7:0]      regAddr,
   output logic            regWriteEn,
   output logic [7:0]      regWriteData,
   input  wire logic [7:0] regReadData
);
   initial begin
      regAddr = 8'h00;
      regWriteEn = 1'b0;
      regWriteData = 8'h00;
   end
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk);
      regAddr <= addr;
      regWriteEn <= 1'b1;
      regWriteData <= data;
      @(posedge clk);
      regWriteEn <= 1'b0;
      // Data is turned over once the strobe drops, so stale use shows up.
      regWriteData <= ~data;
   endtask
   // The answer is registered, so it is taken one edge after the address.
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      @(posedge clk);
      regAddr <= addr;
      regWriteEn <= 1'b0;
      @(posedge clk);
      #1 data = regReadData;
   endtask
endmodule

// ===== sim/hes_host_error_bank_tb.sv
// Self-checking bench for the host error status bank.
`timescale 1ns/1ps
module hes_host_error_bank_tb;
   import hes_pkg::*;
   logic        clk, rst, regWriteEn, regulatorOneHotInput;
   logic        regulatorTwoHotInputN, fuseInputEight, fuseInputNine;
   logic        olderRegulatorStandard, hostErrorFlag;
   logic        coreSupplyOneMismatch, coreSupplyTwoMismatch;
   logic [7:0]  regAddr, regWriteData, regReadData;
   logic [7:0]  zoneMaskSelect, voltageMaskSelect, diodeMaskSelect;
   logic [3:0]  zoneLimitFault, diodePairFault;
   logic [15:0] voltageChannelFault;
   hes_sleep_t  sleepState;
   int          fails, samplesChecked;

   hes_host_error_bank dut (.clk, .rst, .regAddr, .regWriteEn,
      .regWriteData, .regReadData, .sleepState, .zoneMaskSelect,
      .voltageMaskSelect, .diodeMaskSelect, .zoneLimitFault,
      .regulatorOneHotInput, .regulatorTwoHotInputN, .voltageChannelFault,
      .diodePairFault, .fuseInputEight, .fuseInputNine,
      .olderRegulatorStandard, .coreSupplyOneMismatch,
      .coreSupplyTwoMismatch, .hostErrorFlag);
   hes_host_model host (.clk, .regAddr, .regWriteEn, .regWriteData,
      .regReadData);

   always #5 clk = ~clk;

   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      samplesChecked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic close_out();
      $display("checked %0d mismatches %0d", samplesChecked, fails);
      if (fails == 0 && samplesChecked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic drive_events(input logic on);
      @(posedge clk);
      zoneLimitFault <= {4{on}};
      regulatorOneHotInput <= on;
      regulatorTwoHotInputN <= ~on;
      voltageChannelFault <= {16{on}};
      diodePairFault <= {4{on}};
      fuseInputEight <= on;
      fuseInputNine <= on;
      coreSupplyOneMismatch <= on;
      coreSupplyTwoMismatch <= on;
   endtask

   // Reads 48h..4Bh in turn and compares them with one packed word.
   task automatic read_all(input logic [31:0] exp);
      logic [7:0] got;
      for (int i = 0; i < 4; i++) begin
         host.read_reg(ZONE_REG_ADDR + 8'(i), got);
         chk("status", exp[31-8*i -: 8], got);
      end
      chk("flag", {7'h0, exp != 0}, {7'h0, hostErrorFlag});
   endtask

   task automatic clear_all();
      for (int i = 0; i < 4; i++) begin
         host.write_reg(ZONE_REG_ADDR + 8'(i), 8'hff);
      end
      read_all(32'h0);
   endtask

   task automatic check_reset();
      logic [7:0] got;
      read_all(32'h0);
      host.write_reg(8'h50, 8'hff);
      host.read_reg(8'h50, got);
      chk("unmapped", 8'h00, got);
   endtask

   task automatic check_sticky();
      logic [7:0] got;
      @(posedge clk);
      zoneLimitFault <= 4'h1;
      host.write_reg(ZONE_REG_ADDR, 8'h01);
      host.read_reg(ZONE_REG_ADDR, got);
      chk("refused clear", 8'h01, got);
      @(posedge clk);
      zoneLimitFault <= 4'h0;
      host.write_reg(ZONE_REG_ADDR, 8'hfe);
      host.read_reg(ZONE_REG_ADDR, got);
      chk("zero write", 8'h01, got);
      clear_all();
   endtask

   // Single events show some bit positions in each register; fuses are off in this mode.
   task automatic check_mapping();
      @(posedge clk);
      olderRegulatorStandard <= 1'b0;
      zoneLimitFault <= 4'h4;
      regulatorTwoHotInputN <= 1'b0;
      voltageChannelFault <= 16'h8001;
      diodePairFault <= 4'h5;
      fuseInputEight <= 1'b1;
      coreSupplyTwoMismatch <= 1'b1;
      drive_events(1'b0);
      read_all(32'h24018061);
      @(posedge clk);
      olderRegulatorStandard <= 1'b1;
      clear_all();
   endtask

   task automatic check_bank(input hes_sleep_t st, input logic [23:0] sel,
                             input logic [31:0] exp);
      @(posedge clk);
      sleepState <= st;
      {zoneMaskSelect, voltageMaskSelect, diodeMaskSelect} <= sel;
      drive_events(1'b1);
      drive_events(1'b0);
      read_all(exp);
      clear_all();
   endtask

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      fails = 0;
      samplesChecked = 0;
      sleepState = SLEEP_S0;
      {zoneMaskSelect, voltageMaskSelect, diodeMaskSelect} = 24'h0;
      olderRegulatorStandard = 1'b1;
      {zoneLimitFault, diodePairFault, voltageChannelFault} = 24'h0;
      {regulatorOneHotInput, fuseInputEight, fuseInputNine} = 3'h0;
      {coreSupplyOneMismatch, coreSupplyTwoMismatch} = 2'h0;
      regulatorTwoHotInputN = 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      check_reset();
      check_sticky();
      check_mapping();
      check_bank(SLEEP_S0, 24'hffffff, 32'h3fffffff);
      check_bank(SLEEP_S1, 24'hffffff, 32'h3fffffff);
      check_bank(SLEEP_S3, 24'hffffff, 32'h0c008000);
      check_bank(SLEEP_S45, 24'h000000, 32'h0f00b8c3);
      check_bank(SLEEP_S3, 24'h010841, 32'h0e00b082);
      close_out();
   end

   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      close_out();
   end
endmodule
